// *** hw/cpm_pkg.sv ***
// Purpose: Shared constants and types for the programmer-visible core register set.
// Assumes: One 250 MHz clock, synchronous active-high reset, APB register access.
// Notes:   Offsets are APB byte addresses; every register sits in one aligned word.
package cpm_pkg;

  // Data path and address widths.
  localparam int DATA_W = 8;
  localparam int ADDR_W = 13;
  localparam int SP_W   = 6;
  localparam int FLAG_W = 5;

  // Bit positions inside the condition flags.
  localparam int FLG_H = 4;
  localparam int FLG_I = 3;
  localparam int FLG_N = 2;
  localparam int FLG_Z = 1;
  localparam int FLG_C = 0;

  // Values after reset.
  localparam logic [SP_W-1:0]   SP_RESET    = 6'h3F;
  localparam logic [6:0]        STK_PREFIX  = 7'h03;
  localparam logic [FLAG_W-1:0] FLAGS_RESET = 5'h08;
  localparam logic [7:0]        CTRL_RESET  = 8'h03;

  // Vector addresses, high byte first.
  localparam logic [ADDR_W-1:0] VEC_RST = 13'h1FFE;
  localparam logic [ADDR_W-1:0] VEC_SWI = 13'h1FFC;
  localparam logic [ADDR_W-1:0] VEC_IRQ = 13'h1FFA;
  localparam logic [ADDR_W-1:0] VEC_TMR = 13'h1FF8;

  // Stack frame sizes, stored as index of the last byte.
  localparam logic [2:0] LAST_INT  = 3'h4;
  localparam logic [2:0] LAST_CALL = 3'h1;

  // Cycles from the decision to issue a read until its data is captured.
  localparam logic [1:0] READ_LAT = 2'h2;

  // APB register byte offsets.
  localparam logic [7:0] OFF_ACC    = 8'h00;
  localparam logic [7:0] OFF_IDX    = 8'h04;
  localparam logic [7:0] OFF_FLAGS  = 8'h08;
  localparam logic [7:0] OFF_SP     = 8'h0C;
  localparam logic [7:0] OFF_PC     = 8'h10;
  localparam logic [7:0] OFF_CTRL   = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;

  // Control and status bit positions.
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_TMR_EN = 1;
  localparam int STS_IRQ     = 0;
  localparam int STS_TMR     = 1;
  localparam int STS_BUSY    = 2;

  // Operations requested by the instruction decoder.
  typedef enum logic [4:0] {
    OP_NOP  = 5'h00, OP_LDA  = 5'h01, OP_LDX  = 5'h02, OP_ADD  = 5'h03,
    OP_ADC  = 5'h04, OP_SUB  = 5'h05, OP_AND  = 5'h06, OP_ROL  = 5'h07,
    OP_BTST = 5'h08, OP_CLI  = 5'h09, OP_SEI  = 5'h0A, OP_RSP  = 5'h0B,
    OP_JMP  = 5'h0C, OP_CALL = 5'h0D, OP_RTS  = 5'h0E, OP_RTI  = 5'h0F,
    OP_SWI  = 5'h10
  } cpm_op_e;

  // Stack and vector sequencer states.
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PUSH = 4'b0010,
    ST_PULL = 4'b0100,
    ST_VEC  = 4'b1000
  } cpm_state_e;

endpackage

// *** hw/cpm_alu.sv ***
// Purpose: Eight-bit adder and subtractor with half carry and carry out.
// Assumes: Purely combinational, used by the register set on the same clock.
// Notes:   Borrow is reported on the carry output during subtraction.
`timescale 1ns/1ps
module cpm_alu
  import cpm_pkg::*;
(
  input  logic [DATA_W-1:0] a,
  input  logic [DATA_W-1:0] b,
  input  logic              cin,
  input  logic              sub,
  output logic [DATA_W-1:0] sum,
  output logic              half,
  output logic              cout
);

  logic [DATA_W:0] add_w;
  logic [DATA_W:0] dif_w;
  logic [4:0]      nib_w;

  // Full sum, difference and low nibble sum kept one bit wider for the carries.
  assign add_w = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign dif_w = {1'b0, a} - {1'b0, b};
  assign nib_w = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};

  // Carry out of bit 3 into bit 4 only has meaning for additions.
  assign sum  = sub ? dif_w[DATA_W-1:0] : add_w[DATA_W-1:0];
  assign half = nib_w[4];
  assign cout = sub ? dif_w[DATA_W] : add_w[DATA_W];

endmodule // cpm_alu

// *** hw/cpm_regs.sv ***
// Purpose: Accumulator, index, condition flags, stack pointer and program counter of the core.
// Assumes: Synchronous stack RAM with data valid two cycles after the read decision.
// Notes:   Registers are readable over APB; control enables interrupt sources.
`timescale 1ns/1ps
module cpm_regs
  import cpm_pkg::*;
(
  input  logic              sys_clk,
  input  logic              rst,
  // APB slave.
  input  logic              psel,
  input  logic              penable,
  input  logic              pwrite,
  input  logic [7:0]        paddr,
  input  logic [31:0]       pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Instruction decoder side.
  input  cpm_op_e           op_code,
  input  logic              op_valid,
  input  logic [DATA_W-1:0] op_data,
  input  logic [2:0]        op_bit,
  input  logic [ADDR_W-1:0] op_addr,
  input  logic              pc_inc,
  input  logic              insn_done,
  // Interrupt sources.
  input  logic              irq_pin_n,
  input  logic              tmr_req,
  // Stack RAM and vector memory.
  output logic [ADDR_W-1:0] mem_addr,
  output logic [DATA_W-1:0] mem_wdata,
  output logic              mem_we,
  output logic              mem_re,
  input  logic [DATA_W-1:0] mem_rdata,
  // Register view.
  output logic [DATA_W-1:0] acc,
  output logic [DATA_W-1:0] idx,
  output logic [FLAG_W-1:0] flags,
  output logic [SP_W-1:0]   stack_ptr,
  output logic [ADDR_W-1:0] program_counter,
  output logic              busy
);

  cpm_state_e        state_r, state_nxt;
  logic [DATA_W-1:0] acc_r, acc_nxt;
  logic [DATA_W-1:0] idx_r, idx_nxt;
  logic [FLAG_W-1:0] flg_r, flg_nxt;
  logic [SP_W-1:0]   sp_r, sp_nxt;
  logic [ADDR_W-1:0] pc_r, pc_nxt;
  logic [ADDR_W-1:0] tgt_r, tgt_nxt;
  logic [ADDR_W-1:0] vec_r, vec_nxt;
  logic [2:0]        cnt_r, cnt_nxt;
  logic [2:0]        last_r, last_nxt;
  logic [1:0]        ph_r, ph_nxt;
  logic              ent_r, ent_nxt;
  logic [DATA_W-1:0] vhi_r, vhi_nxt;
  logic [ADDR_W-1:0] maddr_r, maddr_nxt;
  logic [DATA_W-1:0] mwd_r, mwd_nxt;
  logic              mwe_r, mwe_nxt;
  logic              mre_r, mre_nxt;
  logic              irq_meta_r, irq_sync_r;
  logic              irq_pend_r, tmr_pend_r;
  logic [7:0]        ctrl_r;
  logic [31:0]       prdata_r;
  logic              pready_r, pslverr_r;
  logic              irq_clr, tmr_clr;

  // Arithmetic unit shared by add, add with carry and subtract.
  logic [DATA_W-1:0] alu_sum;
  logic              alu_half, alu_cout;

  cpm_alu u_alu (
    .a    (acc_r),
    .b    (op_data),
    .cin  (flg_r[FLG_C]),
    .sub  (op_code == OP_SUB),
    .sum  (alu_sum),
    .half (alu_half),
    .cout (alu_cout)
  );

  // Sequencer helpers: stack address, byte to push and slot of a pulled byte.
  wire              idle_w    = (state_r == ST_IDLE);
  wire [ADDR_W-1:0] push_addr = {STK_PREFIX, sp_r};
  wire [SP_W-1:0]   sp_up     = SP_W'(sp_r + 6'h01);
  wire [ADDR_W-1:0] pull_addr = {STK_PREFIX, sp_up};
  wire [2:0]        pull_slot = 3'(last_r - cnt_r);
  wire              last_byte = (cnt_r == last_r);
  wire              data_rdy  = (ph_r == READ_LAT);
  wire [ADDR_W-1:0] vec_addr  = ADDR_W'(vec_r + {12'h000, cnt_r[0]});

  // Requests stay pending through the mask and are taken only at an instruction end.
  wire irq_lvl  = ~irq_sync_r & ctrl_r[CTRL_IRQ_EN];
  wire tmr_lvl  = tmr_req & ctrl_r[CTRL_TMR_EN];
  wire hw_take  = idle_w & insn_done & ~flg_r[FLG_I]
                  & (irq_pend_r | tmr_pend_r);
  wire irq_wins = irq_pend_r;

  // Push order is PC low, PC high, index, accumulator, flags.
  logic [DATA_W-1:0] push_byte;
  always_comb begin
    case (cnt_r)
      3'h0:    push_byte = pc_r[7:0];
      3'h1:    push_byte = {3'h0, pc_r[12:8]};
      3'h2:    push_byte = idx_r;
      3'h3:    push_byte = acc_r;
      3'h4:    push_byte = {3'h0, flg_r};
      default: push_byte = 8'h00;
    endcase
  end

  // Result flags for logical and load results.
  function automatic logic [FLAG_W-1:0] nz_flags(input logic [FLAG_W-1:0] f,
                                                 input logic [DATA_W-1:0] v);
    logic [FLAG_W-1:0] r;
    r        = f;
    r[FLG_N] = v[DATA_W-1];
    r[FLG_Z] = (v == 8'h00);
    return r;
  endfunction

  // Next state of the whole register set and the stack sequencer.
  always_comb begin
    state_nxt = state_r;
    acc_nxt   = acc_r;
    idx_nxt   = idx_r;
    flg_nxt   = flg_r;
    sp_nxt    = sp_r;
    pc_nxt    = pc_r;
    tgt_nxt   = tgt_r;
    vec_nxt   = vec_r;
    cnt_nxt   = cnt_r;
    last_nxt  = last_r;
    ph_nxt    = ph_r;
    ent_nxt   = ent_r;
    vhi_nxt   = vhi_r;
    maddr_nxt = maddr_r;
    mwd_nxt   = mwd_r;
    mwe_nxt   = 1'b0;
    mre_nxt   = 1'b0;
    irq_clr   = 1'b0;
    tmr_clr   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (pc_inc) begin
          pc_nxt = ADDR_W'(pc_r + 13'h0001);
        end
        if (hw_take) begin
          // External request is served before the timer.
          state_nxt = ST_PUSH;
          cnt_nxt   = 3'h0;
          last_nxt  = LAST_INT;
          ent_nxt   = 1'b1;
          vec_nxt   = irq_wins ? VEC_IRQ : VEC_TMR;
          irq_clr   = irq_wins;
          tmr_clr   = ~irq_wins;
        end else if (op_valid) begin
          case (op_code)
            OP_LDA: begin
              acc_nxt = op_data;
              flg_nxt = nz_flags(flg_r, op_data);
            end
            OP_LDX: begin
              idx_nxt = op_data;
              flg_nxt = nz_flags(flg_r, op_data);
            end
            OP_ADD, OP_ADC: begin
              acc_nxt        = alu_sum;
              flg_nxt        = nz_flags(flg_r, alu_sum);
              flg_nxt[FLG_H] = alu_half;
              flg_nxt[FLG_C] = alu_cout;
            end
            OP_SUB: begin
              acc_nxt        = alu_sum;
              flg_nxt        = nz_flags(flg_r, alu_sum);
              flg_nxt[FLG_C] = alu_cout;
            end
            OP_AND: begin
              acc_nxt = acc_r & op_data;
              flg_nxt = nz_flags(flg_r, acc_r & op_data);
            end
            OP_ROL: begin
              acc_nxt        = {acc_r[6:0], flg_r[FLG_C]};
              flg_nxt        = nz_flags(flg_r, {acc_r[6:0], flg_r[FLG_C]});
              flg_nxt[FLG_C] = acc_r[7];
            end
            OP_BTST: flg_nxt[FLG_C] = op_data[op_bit];
            OP_CLI:  flg_nxt[FLG_I] = 1'b0;
            OP_SEI:  flg_nxt[FLG_I] = 1'b1;
            OP_RSP:  sp_nxt = SP_RESET;
            OP_JMP:  pc_nxt = op_addr;
            OP_CALL: begin
              state_nxt = ST_PUSH;
              cnt_nxt   = 3'h0;
              last_nxt  = LAST_CALL;
              ent_nxt   = 1'b0;
              tgt_nxt   = op_addr;
            end
            OP_RTS, OP_RTI: begin
              state_nxt = ST_PULL;
              cnt_nxt   = 3'h0;
              ph_nxt    = 2'h0;
              last_nxt  = (op_code == OP_RTI) ? LAST_INT : LAST_CALL;
            end
            OP_SWI: begin
              // Taken whatever the mask holds.
              state_nxt = ST_PUSH;
              cnt_nxt   = 3'h0;
              last_nxt  = LAST_INT;
              ent_nxt   = 1'b1;
              vec_nxt   = VEC_SWI;
            end
            default: flg_nxt = flg_r;
          endcase
        end
      end
      ST_PUSH: begin
        mwe_nxt   = 1'b1;
        maddr_nxt = push_addr;
        mwd_nxt   = push_byte;
        sp_nxt    = SP_W'(sp_r - 6'h01);
        cnt_nxt   = 3'(cnt_r + 3'h1);
        if (last_byte) begin
          cnt_nxt = 3'h0;
          ph_nxt  = 2'h0;
          if (ent_r) begin
            // Mask is set only after the old flags went onto the stack.
            flg_nxt[FLG_I] = 1'b1;
            state_nxt      = ST_VEC;
          end else begin
            pc_nxt    = tgt_r;
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_PULL: begin
        ph_nxt = 2'(ph_r + 2'h1);
        if (ph_r == 2'h0) begin
          sp_nxt    = sp_up;
          mre_nxt   = 1'b1;
          maddr_nxt = pull_addr;
        end
        if (data_rdy) begin
          ph_nxt  = 2'h0;
          cnt_nxt = 3'(cnt_r + 3'h1);
          case (pull_slot)
            3'h0:    pc_nxt[7:0]  = mem_rdata;
            3'h1:    pc_nxt[12:8] = mem_rdata[4:0];
            3'h2:    idx_nxt      = mem_rdata;
            3'h3:    acc_nxt      = mem_rdata;
            3'h4:    flg_nxt      = mem_rdata[FLAG_W-1:0];
            default: acc_nxt      = acc_r;
          endcase
          if (last_byte) begin
            state_nxt = ST_IDLE;
          end
        end
      end
      ST_VEC: begin
        ph_nxt = 2'(ph_r + 2'h1);
        if (ph_r == 2'h0) begin
          mre_nxt   = 1'b1;
          maddr_nxt = vec_addr;
        end
        if (data_rdy) begin
          ph_nxt  = 2'h0;
          cnt_nxt = 3'(cnt_r + 3'h1);
          vhi_nxt = mem_rdata;
          if (cnt_r[0]) begin
            pc_nxt    = {vhi_r[4:0], mem_rdata};
            state_nxt = ST_IDLE;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Core registers; reset starts a reset-vector fetch with the mask set.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= ST_VEC;
      acc_r   <= 8'h00;
      idx_r   <= 8'h00;
      flg_r   <= FLAGS_RESET;
      sp_r    <= SP_RESET;
      pc_r    <= 13'h0000;
      tgt_r   <= 13'h0000;
      vec_r   <= VEC_RST;
      cnt_r   <= 3'h0;
      last_r  <= 3'h0;
      ph_r    <= 2'h0;
      ent_r   <= 1'b0;
      vhi_r   <= 8'h00;
    end else begin
      state_r <= state_nxt;
      acc_r   <= acc_nxt;
      idx_r   <= idx_nxt;
      flg_r   <= flg_nxt;
      sp_r    <= sp_nxt;
      pc_r    <= pc_nxt;
      tgt_r   <= tgt_nxt;
      vec_r   <= vec_nxt;
      cnt_r   <= cnt_nxt;
      last_r  <= last_nxt;
      ph_r    <= ph_nxt;
      ent_r   <= ent_nxt;
      vhi_r   <= vhi_nxt;
    end
  end

  // Memory strobes are registered so the RAM sees clean, glitch-free controls.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      maddr_r <= 13'h0000;
      mwd_r   <= 8'h00;
      mwe_r   <= 1'b0;
      mre_r   <= 1'b0;
    end else begin
      maddr_r <= maddr_nxt;
      mwd_r   <= mwd_nxt;
      mwe_r   <= mwe_nxt;
      mre_r   <= mre_nxt;
    end
  end

  // The request pin is asynchronous, so it passes two flops before any use.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_meta_r <= 1'b1;
      irq_sync_r <= 1'b1;
    end else begin
      irq_meta_r <= irq_pin_n;
      irq_sync_r <= irq_meta_r;
    end
  end

  // Pending latches; a new request in the clearing cycle wins over the clear.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_pend_r <= 1'b0;
      tmr_pend_r <= 1'b0;
    end else begin
      irq_pend_r <= irq_lvl | (irq_pend_r & ~irq_clr);
      tmr_pend_r <= tmr_lvl | (tmr_pend_r & ~tmr_clr);
    end
  end

  // APB decode; the answer is prepared in the setup cycle, so there are no wait states.
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pready_r & pwrite;
  wire hit_ro    = (paddr == OFF_ACC) | (paddr == OFF_IDX) | (paddr == OFF_FLAGS)
                   | (paddr == OFF_SP) | (paddr == OFF_PC) | (paddr == OFF_STATUS);
  wire hit_ctrl  = (paddr == OFF_CTRL);
  wire [31:0] rd_mux =
      (paddr == OFF_ACC)    ? {24'h000000, acc_r} :
      (paddr == OFF_IDX)    ? {24'h000000, idx_r} :
      (paddr == OFF_FLAGS)  ? {27'h0, flg_r} :
      (paddr == OFF_SP)     ? {26'h0, sp_r} :
      (paddr == OFF_PC)     ? {19'h0, pc_r} :
      hit_ctrl              ? {24'h000000, ctrl_r} :
      (paddr == OFF_STATUS) ? {29'h0, ~idle_w, tmr_pend_r, irq_pend_r} :
                              32'h00000000;

  // Bus answer and control register.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h00000000;
      ctrl_r    <= CTRL_RESET;
    end else begin
      pready_r  <= apb_setup;
      pslverr_r <= apb_setup & ~(hit_ro | hit_ctrl);
      prdata_r  <= (apb_setup & ~pwrite) ? rd_mux : 32'h00000000;
      if (apb_wr && hit_ctrl) begin
        ctrl_r <= pwdata[7:0];
      end
    end
  end

  // Every output but busy comes straight from a register; busy is the inverted idle bit of state_r.
  assign prdata          = prdata_r;
  assign pready          = pready_r;
  assign pslverr         = pslverr_r;
  assign mem_addr        = maddr_r;
  assign mem_wdata       = mwd_r;
  assign mem_we          = mwe_r;
  assign mem_re          = mre_r;
  assign acc             = acc_r;
  assign idx             = idx_r;
  assign flags           = flg_r;
  assign stack_ptr       = sp_r;
  assign program_counter = pc_r;
  assign busy            = ~state_r[0];

endmodule // cpm_regs

// *** sim/cpm_regs_properties.sv ***
// Purpose: Concurrent checks on the port behaviour of the core register set.
// Assumes: Bound to cpm_regs; one clock, synchronous active-high reset.
// Notes:   Stack timing follows the hand-over walk for calls and traps.
`timescale 1ns/1ps
module cpm_regs_properties
  import cpm_pkg::*;
(
  input logic              sys_clk,
  input logic              rst,
  input cpm_op_e           op_code,
  input logic              op_valid,
  input logic [DATA_W-1:0] op_data,
  input logic              pc_inc,
  input logic              insn_done,
  input logic [ADDR_W-1:0] mem_addr,
  input logic              mem_we,
  input logic              mem_re,
  input logic [DATA_W-1:0] acc,
  input logic [FLAG_W-1:0] flags,
  input logic [SP_W-1:0]   stack_ptr,
  input logic [ADDR_W-1:0] program_counter,
  input logic              busy
);
  // An op counts as taken only when idle and no hardware entry can claim the edge.
  wire take = op_valid && !busy && !insn_done;

  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  reset_state_a: assert property ($past(rst) |-> stack_ptr == SP_RESET && flags == FLAGS_RESET)
    else $error("state after reset wrong");
  reset_vector_a: assert property ($fell(rst) |-> ##[0:6] (mem_re && mem_addr == VEC_RST))
    else $error("reset vector not fetched");
  stack_reset_a: assert property (take && op_code == OP_RSP |=> stack_ptr == SP_RESET)
    else $error("stack reset failed");
  load_flags_a: assert property (take && op_code == OP_LDA |=> acc == $past(op_data)
    && flags[FLG_N] == $past(op_data[7]) && flags[FLG_Z] == ($past(op_data) == 8'h00))
    else $error("load result or flags wrong");
  stack_region_a: assert property (mem_we |-> mem_addr[12:6] == STK_PREFIX)
    else $error("push outside stack page");
  push_down_a: assert property (mem_we ##1 mem_we |-> mem_addr[5:0] == $past(mem_addr[5:0]) - 6'h01)
    else $error("push order wrong");
  call_bytes_a: assert property (take && op_code == OP_CALL |=> busy ##1 mem_we [*2] ##1 !mem_we)
    else $error("call frame size wrong");
  trap_bytes_a: assert property (take && op_code == OP_SWI |=> ##1 mem_we [*5] ##1 !mem_we)
    else $error("trap frame size wrong");
  trap_mask_a: assert property (take && op_code == OP_SWI |-> ##[2:12] flags[FLG_I])
    else $error("trap left mask clear");
  mask_hold_a: assert property (insn_done && flags[FLG_I] && !busy && !op_valid |=> !busy)
    else $error("masked request taken");
  pc_step_a: assert property (pc_inc && !busy && !op_valid && !insn_done
    |=> program_counter == $past(program_counter) + 13'h0001)
    else $error("program counter step wrong");
endmodule // cpm_regs_properties

bind cpm_regs cpm_regs_properties cpm_regs_properties_i (.sys_clk, .rst, .op_code, .op_valid,
  .op_data, .pc_inc, .insn_done, .mem_addr, .mem_we, .mem_re, .acc, .flags, .stack_ptr,
  .program_counter, .busy);

// *** sim/cpm_mem_model.sv ***
// Purpose: Behavioural stack RAM and vector memory facing the core.
// Assumes: Read data stands exactly one cycle after the read strobe is seen.
// Notes:   Outside that cycle the data lines toggle, so stale data never matches.
`timescale 1ns/1ps
module cpm_mem_model
  import cpm_pkg::*;
#(
  parameter logic [ADDR_W-1:0] RST_PC = 13'h0100,
  parameter logic [ADDR_W-1:0] SWI_PC = 13'h0200,
  parameter logic [ADDR_W-1:0] IRQ_PC = 13'h0300,
  parameter logic [ADDR_W-1:0] TMR_PC = 13'h0400
)
(
  input  logic              sys_clk,
  input  logic [ADDR_W-1:0] mem_addr,
  input  logic [DATA_W-1:0] mem_wdata,
  input  logic              mem_we,
  input  logic              mem_re,
  output logic [DATA_W-1:0] mem_rdata = 8'h00
);
  logic [DATA_W-1:0] mem [0:8191];

  // Vectors are stored high byte first.
  initial begin
    {mem[VEC_RST], mem[VEC_RST+1]} = {3'h0, RST_PC};
    {mem[VEC_SWI], mem[VEC_SWI+1]} = {3'h0, SWI_PC};
    {mem[VEC_IRQ], mem[VEC_IRQ+1]} = {3'h0, IRQ_PC};
    {mem[VEC_TMR], mem[VEC_TMR+1]} = {3'h0, TMR_PC};
  end

  // Writes land at the strobe edge; a read answers for one cycle only.
  always @(posedge sys_clk) begin
    if (mem_we) mem[mem_addr] <= mem_wdata;
    mem_rdata <= mem_re ? mem[mem_addr] : ~mem_rdata;
  end
endmodule // cpm_mem_model

// *** sim/tb_cpm_regs.sv ***
// Purpose: Self-checking bench for the core register set.
// Assumes: Memory model answers one cycle after the read strobe.
// Notes:   Each scenario drives the block and judges it before returning.
`timescale 1ns/1ps
module tb_cpm_regs
  import cpm_pkg::*;
;
  localparam logic [12:0] RST_PC = 13'h0100;
  localparam logic [12:0] SWI_PC = 13'h0200;
  localparam logic [12:0] IRQ_PC = 13'h0300;
  localparam logic [12:0] TMR_PC = 13'h0400;
  logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pc_inc = 1'b0, insn_done = 1'b0, op_valid = 1'b0, tmr_req = 1'b0, irq_pin_n = 1'b1;
  logic [7:0]  paddr = 8'h00, op_data = 8'h00, mem_wdata, mem_rdata, acc, idx;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [12:0] op_addr = 13'h0, mem_addr, program_counter;
  logic [2:0]  op_bit = 3'h0;
  logic [4:0]  flags;
  logic [5:0]  stack_ptr;
  logic        pready, pslverr, mem_we, mem_re, busy, e;
  cpm_op_e     op_code = OP_NOP;
  int          mismatches = 0, n_checks = 0;

  // Free-running 250 MHz clock.
  always #2 sys_clk = ~sys_clk;

  cpm_regs cpm_regs_i (.sys_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .op_code, .op_valid, .op_data, .op_bit, .op_addr, .pc_inc, .insn_done,
    .irq_pin_n, .tmr_req, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata, .acc, .idx,
    .flags, .stack_ptr, .program_counter, .busy);
  cpm_mem_model #(.RST_PC(RST_PC), .SWI_PC(SWI_PC), .IRQ_PC(IRQ_PC), .TMR_PC(TMR_PC))
    cpm_mem_model_i (.sys_clk, .mem_addr, .mem_wdata, .mem_we, .mem_re, .mem_rdata);

  task automatic summarize;
    if (mismatches == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One bit above the data word so that the bus error flag is compared as well.
  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    n_checks++;
    if (g !== x) begin
      mismatches++;
      $display("CHECK FAILED %0t got %h want %h", $time, g, x);
    end
  endtask

  // Waits are bounded so a stuck sequencer shows up as a mismatch, not a hang.
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk(busy, 1'b0);
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  // Only the watchdog ends a wait that never sees pready.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic op(input cpm_op_e c, input logic [7:0] d, input logic [2:0] b,
                    input logic [12:0] a);
    op_code <= c;
    op_data <= d;
    op_bit <= b;
    op_addr <= a;
    op_valid <= 1'b1;
    @(posedge sys_clk);
    op_valid <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wait_idle();
  endtask

  task automatic done_pulse;
    insn_done <= 1'b1;
    @(posedge sys_clk);
    insn_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    wait_idle();
  endtask

  task automatic alu(input cpm_op_e c, input logic [7:0] d, input logic [7:0] ea,
                     input logic [4:0] ef);
    op(c, d, 3'h2, 13'h0);
    chk({ea, 3'h0, ef}, {acc, 3'h0, flags});
  endtask

  task automatic t_reset;
    wait_idle();
    chk(program_counter, RST_PC);
    chk({flags, stack_ptr, acc, idx}, {FLAGS_RESET, SP_RESET, 16'h0});
    apb(1'b0, OFF_SP, 32'h0);
    chk({e, q}, {1'b0, 32'h3F});
    apb(1'b1, OFF_ACC, 32'hFF);
    apb(1'b0, OFF_ACC, 32'h0);
    chk({e, q}, 33'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk({e, q}, {1'b1, 32'h0});
  endtask

  task automatic t_alu;
    alu(OP_LDA, 8'h0F, 8'h0F, 5'h08);
    alu(OP_ADD, 8'h01, 8'h10, 5'h18);
    alu(OP_ADD, 8'hF0, 8'h00, 5'h0B);
    alu(OP_ADC, 8'h7F, 8'h80, 5'h1C);
    alu(OP_SUB, 8'h81, 8'hFF, 5'h1D);
    alu(OP_AND, 8'h0F, 8'h0F, 5'h19);
    op(OP_ROL, 8'h00, 3'h2, 13'h0);
    chk(flags[FLG_C], 1'b0);
    op(OP_BTST, 8'h04, 3'h2, 13'h0);
    chk(flags[FLG_C], 1'b1);
    op(OP_LDX, 8'h5A, 3'h0, 13'h0);
    chk(idx, 8'h5A);
  endtask

  task automatic t_stack;
    pc_inc <= 1'b1;
    @(posedge sys_clk);
    pc_inc <= 1'b0;
    @(posedge sys_clk);
    chk(program_counter, RST_PC + 13'h1);
    op(OP_CALL, 8'h00, 3'h0, 13'h1ABC);
    chk({program_counter, stack_ptr}, {13'h1ABC, 6'h3D});
    op(OP_RTS, 8'h00, 3'h0, 13'h0);
    chk({program_counter, stack_ptr}, {RST_PC + 13'h1, 6'h3F});
    op(OP_JMP, 8'h00, 3'h0, 13'h1FFF);
    chk(program_counter, 13'h1FFF);
    for (int i = 0; i < 33; i++) begin
      op(OP_CALL, 8'h00, 3'h0, RST_PC);
    end
    chk(stack_ptr, 6'h3D);
    op(OP_RSP, 8'h00, 3'h0, 13'h0);
    chk(stack_ptr, 6'h3F);
  endtask

  // The trap is taken with the mask still set from reset.
  task automatic t_trap;
    op(OP_LDA, 8'hA5, 3'h0, 13'h0);
    op(OP_SWI, 8'h00, 3'h0, 13'h0);
    chk({program_counter, stack_ptr, flags[FLG_I]}, {SWI_PC, 6'h3A, 1'b1});
    op(OP_LDA, 8'h00, 3'h0, 13'h0);
    op(OP_LDX, 8'h00, 3'h0, 13'h0);
    op(OP_RTI, 8'h00, 3'h0, 13'h0);
    chk({program_counter, stack_ptr, acc, idx}, {RST_PC, 6'h3F, 16'hA55A});
    chk(flags[3:0], 4'hD);
  endtask

  task automatic t_hw;
    irq_pin_n <= 1'b0;
    tmr_req <= 1'b1;
    repeat (4) @(posedge sys_clk);
    irq_pin_n <= 1'b1;
    tmr_req <= 1'b0;
    repeat (4) @(posedge sys_clk);
    done_pulse();
    chk(program_counter, RST_PC);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk({e, q}, {1'b0, 32'h3});
    op(OP_CLI, 8'h00, 3'h0, 13'h0);
    repeat (4) @(posedge sys_clk);
    chk({busy, program_counter}, {1'b0, RST_PC});
    done_pulse();
    chk({program_counter, flags[FLG_I]}, {IRQ_PC, 1'b1});
    op(OP_RTI, 8'h00, 3'h0, 13'h0);
    chk({program_counter, flags[FLG_I]}, {RST_PC, 1'b0});
    done_pulse();
    chk(program_counter, TMR_PC);
    op(OP_RTI, 8'h00, 3'h0, 13'h0);
    // A trap with the mask clear must set it on entry.
    op(OP_SWI, 8'h00, 3'h0, 13'h0);
    chk({program_counter, flags[FLG_I]}, {SWI_PC, 1'b1});
    op(OP_RTI, 8'h00, 3'h0, 13'h0);
    op(OP_SEI, 8'h00, 3'h0, 13'h0);
    chk(flags[FLG_I], 1'b1);
    // The control register is the only writable one; the write must land.
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b0, OFF_CTRL, 32'h0);
    chk({e, q}, 33'h0);
  endtask

  // Main sequence: reset, then each scenario in turn.
  initial begin
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_alu();
    t_stack();
    t_trap();
    t_hw();
    summarize();
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial begin
    #40000;
    mismatches++;
    summarize();
  end
endmodule // tb_cpm_regs
